//--- design/fbc_engine.sv
// module: self-timed internal page operations (copy, compare, rewrite)
`timescale 1ns/1ns
module fbc_engine
	import fbc_pkg::*;
#(
	parameter int COPY_CYC = PAGE_COPY_TIME_US * CLK_MHZ,
	parameter int CMP_CYC  = COMPARE_TIME_US * CLK_MHZ,
	parameter int REWR_CYC = PAGE_REWRITE_TIME_US * CLK_MHZ
)(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic arr_mismatch,
	fbc_op_if.eng     opi
);
	typedef enum logic [3:0]
	{
		FBC_ENG_IDLE = 4'b0001,
		FBC_ENG_COPY = 4'b0010,
		FBC_ENG_CMP  = 4'b0100,
		FBC_ENG_REWR = 4'b1000
	} fbc_eng_t;

	fbc_eng_t         state_r;
	logic [CNT_W-1:0] cnt_r;
	logic             busy_r;
	logic             mism_r;

	// --------------------------------------------------------------
	// operation sequencer
	// --------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= FBC_ENG_IDLE;
			cnt_r   <= '0;
			busy_r  <= 1'b0;
		end
		else
		begin
			case (state_r)
				FBC_ENG_IDLE:
				begin
					if (opi.start)
					begin
						busy_r <= 1'b1;
						case (opi.op)
							FBC_OP_CMP:
							begin
								state_r <= FBC_ENG_CMP;
								cnt_r   <= CNT_W'(CMP_CYC - 1);
							end
							FBC_OP_REWR:
							begin
								state_r <= FBC_ENG_REWR;
								cnt_r   <= CNT_W'(REWR_CYC - 1);
							end
							default:
							begin
								state_r <= FBC_ENG_COPY;
								cnt_r   <= CNT_W'(COPY_CYC - 1);
							end
						endcase
					end
				end
				FBC_ENG_COPY, FBC_ENG_CMP, FBC_ENG_REWR:
				begin
					if (cnt_r == '0)
					begin
						state_r <= FBC_ENG_IDLE;
						busy_r  <= 1'b0;
					end
					else
						cnt_r <= cnt_r - 1'b1;
				end
				default:
				begin
					state_r <= FBC_ENG_IDLE;
					busy_r  <= 1'b0;
				end
			endcase
		end
	end

	// compare outcome lands when the compare finishes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mism_r <= COMP_RST;
		else if (state_r == FBC_ENG_CMP && cnt_r == '0)
			mism_r <= arr_mismatch;
	end

	assign opi.busy     = busy_r;
	assign opi.mismatch = mism_r;
endmodule

//--- design/fbc_op_if.sv
// interface: operation launch and completion between command decoder and engine
`timescale 1ns/1ns
interface fbc_op_if;
	import fbc_pkg::*;

	logic    start;
	fbc_op_t op;
	logic    busy;
	logic    mismatch;

	modport ctl
	(
		output start,
		output op,
		input  busy,
		input  mismatch
	);

	modport eng
	(
		input  start,
		input  op,
		output busy,
		output mismatch
	);
endinterface

//--- design/fbc_pin_sync.sv
// module: two-flop pin synchroniser with edge detection behind the second stage
`timescale 1ns/1ns
module fbc_pin_sync #(
	parameter int         W       = 5,
	parameter logic [4:0] RST_VAL = 5'h01
)(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;
	logic [W-1:0] prev_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= RST_VAL[W-1:0];
			q_r    <= RST_VAL[W-1:0];
			prev_r <= RST_VAL[W-1:0];
		end
		else
		begin
			meta_r <= d_in;
			q_r    <= meta_r;
			prev_r <= q_r;
		end
	end

	assign q    = q_r;
	assign rise = q_r & ~prev_r;
	assign fall = ~q_r & prev_r;
endmodule

//--- design/fbc_pkg.sv
// package: opcodes, field layout, status bits and timing for the buffer command block
package fbc_pkg;

	// --------------------------------------------------------------
	// opcodes
	// --------------------------------------------------------------
	localparam logic [7:0] OPC_XFER_B1 = 8'h53;
	localparam logic [7:0] OPC_XFER_B2 = 8'h55;
	localparam logic [7:0] OPC_CMP_B1  = 8'h60;
	localparam logic [7:0] OPC_CMP_B2  = 8'h61;
	localparam logic [7:0] OPC_REWR_B1 = 8'h58;
	localparam logic [7:0] OPC_REWR_B2 = 8'h59;
	localparam logic [7:0] OPC_STATUS  = 8'hd7;

	// --------------------------------------------------------------
	// frame and address layout
	// --------------------------------------------------------------
	localparam int         CMD_BITS     = 32;
	localparam logic [5:0] CMD_BITS_W   = 6'h20;
	localparam logic [5:0] OPC_LAST_BIT = 6'h07;
	localparam int         PAGE_W       = 13;
	localparam int         STD_PAGE_LSB = 10;
	localparam int         BIN_PAGE_LSB = 9;

	// --------------------------------------------------------------
	// status bytes
	// --------------------------------------------------------------
	localparam int         SB_RDY      = 7;
	localparam int         SB_COMP     = 6;
	localparam int         SB_DENS_LSB = 2;
	localparam int         SB_PROT     = 1;
	localparam int         SB_PSIZE    = 0;
	localparam logic       PSIZE_STD   = 1'b0;
	localparam logic       PSIZE_BIN   = 1'b1;
	localparam logic       COMP_RST    = 1'b0;
	localparam logic [3:0] STAT_IDX_RST = 4'h0;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_MHZ              = 25;
	localparam int PAGE_COPY_TIME_US    = 200;
	localparam int COMPARE_TIME_US      = 200;
	localparam int PAGE_REWRITE_TIME_US = 25000;
	localparam int CNT_W                = 20;

	typedef enum logic [1:0]
	{
		FBC_OP_COPY = 2'h0,
		FBC_OP_CMP  = 2'h1,
		FBC_OP_REWR = 2'h2
	} fbc_op_t;

endpackage

//--- design/fbc_top.sv
// module: serial command decoder for buffer transfer, compare, rewrite and status read
// --------------------------------------------------------------
// What this block does
// - opcodes 53h/55h copy a page into buffer one/two; three address bytes follow.
// - 528-byte mode address: one dummy bit, thirteen page bits, ten dummy bits.
// - 512-byte mode address: two dummy bits, page from address bits 21..9, nine dummy.
// - command bits load with chip select low; copy starts when chip select rises.
// - busy is reported during the page copy, ready once it finishes.
// - opcodes 60h/61h compare a page with buffer one/two, same address layouts.
// - compare starts on chip select rise, busy throughout, result goes to status bit 6.
// - compare flag is 0 when page and buffer match, 1 when any bit differs.
// - opcodes 58h/59h rewrite a page via buffer one/two, same address layouts.
// - rewrite copies page to buffer then reprograms it, busy until done.
// - status opcode D7h, then one status bit per clock on serial output.
// - status is two bytes, repeating from the first while selected and clocked.
// - status refreshed continuously; ready/busy in both bytes, updated each byte.
// - status read accepted at any moment, even while an operation runs.
// - chip select rise ends status read anywhere and floats serial output.
// - first byte bit 7 is ready/busy, 0 busy and 1 idle.
// - first byte bits 5..2 hold the fixed density code.
// - first byte bit 1 shows sector protection enabled (1) or disabled (0).
// - first byte bit 0 shows page size, 0 for 528 and 1 for 512 bytes.
// - second byte bit 7 repeats ready/busy, 0 busy and 1 ready.
// --------------------------------------------------------------
`timescale 1ns/1ns
module fbc_top
	import fbc_pkg::*;
#(
	parameter int         COPY_CYC     = PAGE_COPY_TIME_US * CLK_MHZ,
	parameter int         CMP_CYC      = COMPARE_TIME_US * CLK_MHZ,
	parameter int         REWR_CYC     = PAGE_REWRITE_TIME_US * CLK_MHZ,
	// density code value is arbitrary
	parameter logic [3:0] DENSITY_CODE = 4'h5
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              cs_n,
	input  wire logic              sck,
	input  wire logic              si,
	input  wire logic              page_size_cfg,
	input  wire logic              protect_en,
	input  wire logic              arr_mismatch,
	output logic                   so,
	output logic                   so_oe,
	output logic                   busy,
	output logic                   arr_start,
	output fbc_op_t                arr_op,
	output logic                   arr_buf,
	output logic      [PAGE_W-1:0] arr_page
);
	// --------------------------------------------------------------
	// pin synchronisation
	// --------------------------------------------------------------
	logic [4:0] pin_q;
	logic [4:0] pin_rise;
	logic [4:0] pin_fall;
	logic       cs_n_s;
	logic       si_s;
	logic       psize_s;
	logic       prot_s;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;

	fbc_pin_sync #(
		.W       (5),
		.RST_VAL (5'h01)
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.d_in ({protect_en, page_size_cfg, si, sck, cs_n}),
		.q    (pin_q),
		.rise (pin_rise),
		.fall (pin_fall)
	);

	assign cs_n_s   = pin_q[0];
	assign si_s     = pin_q[2];
	assign psize_s  = pin_q[3];
	assign prot_s   = pin_q[4];
	assign sck_rise = pin_rise[1] & ~cs_n_s;
	assign sck_fall = pin_fall[1] & ~cs_n_s;
	assign cs_rise  = pin_rise[0];

	// --------------------------------------------------------------
	// engine
	// --------------------------------------------------------------
	fbc_op_if opi ();

	fbc_engine #(
		.COPY_CYC (COPY_CYC),
		.CMP_CYC  (CMP_CYC),
		.REWR_CYC (REWR_CYC)
	) u_engine (
		.clk          (clk),
		.rst          (rst),
		.arr_mismatch (arr_mismatch),
		.opi          (opi)
	);

	// --------------------------------------------------------------
	// decode helpers
	// --------------------------------------------------------------
	function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a, input logic bin);
		logic [PAGE_W-1:0] p;
		if (bin == PSIZE_BIN)
			p = a[BIN_PAGE_LSB +: PAGE_W];
		else
			p = a[STD_PAGE_LSB +: PAGE_W];
		return p;
	endfunction

	function automatic logic opc_known(input logic [7:0] o);
		return o == OPC_XFER_B1 || o == OPC_XFER_B2 || o == OPC_CMP_B1 ||
			o == OPC_CMP_B2 || o == OPC_REWR_B1 || o == OPC_REWR_B2;
	endfunction

	function automatic fbc_op_t opc_kind(input logic [7:0] o);
		fbc_op_t k;
		case (o)
			OPC_CMP_B1, OPC_CMP_B2:   k = FBC_OP_CMP;
			OPC_REWR_B1, OPC_REWR_B2: k = FBC_OP_REWR;
			default:                  k = FBC_OP_COPY;
		endcase
		return k;
	endfunction

	function automatic logic opc_buf2(input logic [7:0] o);
		return o == OPC_XFER_B2 || o == OPC_CMP_B2 || o == OPC_REWR_B2;
	endfunction

	// --------------------------------------------------------------
	// command shift-in
	// --------------------------------------------------------------
	logic [5:0]  bit_cnt_r;
	logic [31:0] cmd_sr_r;
	logic [7:0]  opc_nxt;
	logic        stat_act_r;

	assign opc_nxt = {cmd_sr_r[6:0], si_s};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bit_cnt_r <= '0;
		else if (cs_n_s)
			bit_cnt_r <= '0;
		else if (sck_rise && bit_cnt_r != CMD_BITS_W)
			bit_cnt_r <= bit_cnt_r + 1'b1;
	end

	// bits beyond the frame are not shifted, so the opcode stays on top
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cmd_sr_r <= '0;
		else if (sck_rise && bit_cnt_r != CMD_BITS_W)
			cmd_sr_r <= {cmd_sr_r[30:0], si_s};
	end

	// status read mode entered on the eighth bit of a status opcode
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stat_act_r <= 1'b0;
		else if (cs_n_s)
			stat_act_r <= 1'b0;
		else if (sck_rise && bit_cnt_r == OPC_LAST_BIT && opc_nxt == OPC_STATUS)
			stat_act_r <= 1'b1;
	end

	// --------------------------------------------------------------
	// operation launch on chip select rise
	// --------------------------------------------------------------
	logic              start_r;
	fbc_op_t           op_r;
	logic              buf_r;
	logic [PAGE_W-1:0] page_r;
	logic              busy_r;
	logic              busy_now;
	logic              start_nxt;

	// the launch cycle already counts as busy, so a frame right behind it is dropped
	assign busy_now = opi.busy | start_r;

	// a short frame never reaches the full count and is dropped
	assign start_nxt = cs_rise && bit_cnt_r == CMD_BITS_W && !busy_now &&
		opc_known(cmd_sr_r[31:24]);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			start_r <= 1'b0;
		else
			start_r <= start_nxt;
	end

	// launch fields hold until the next accepted command
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			op_r   <= FBC_OP_COPY;
			buf_r  <= 1'b0;
			page_r <= '0;
		end
		else if (start_nxt)
		begin
			op_r   <= opc_kind(cmd_sr_r[31:24]);
			buf_r  <= opc_buf2(cmd_sr_r[31:24]);
			page_r <= page_of(cmd_sr_r[23:0], psize_s);
		end
	end

	assign opi.start = start_r;
	assign opi.op    = op_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busy_r <= 1'b0;
		else
			busy_r <= busy_now;
	end

	// --------------------------------------------------------------
	// status output
	// --------------------------------------------------------------
	logic [7:0] stat_b1;
	logic [7:0] stat_b2;
	logic [7:0] stat_byte;
	logic [7:0] stat_sr_r;
	logic [3:0] stat_idx_r;
	logic       so_r;
	logic       so_oe_r;

	always_comb
	begin
		stat_b1                      = '0;
		stat_b1[SB_RDY]              = ~busy_now;
		stat_b1[SB_COMP]             = opi.mismatch;
		stat_b1[SB_DENS_LSB +: 4]    = DENSITY_CODE;
		stat_b1[SB_PROT]             = prot_s;
		stat_b1[SB_PSIZE]            = psize_s;
		stat_b2                      = '0;
		stat_b2[SB_RDY]              = ~busy_now;
		stat_byte                    = stat_idx_r[3] ? stat_b2 : stat_b1;
	end

	// byte position: wraps after the second byte to repeat the first
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stat_idx_r <= STAT_IDX_RST;
		else if (cs_n_s)
			stat_idx_r <= STAT_IDX_RST;
		else if (sck_fall && stat_act_r)
			stat_idx_r <= stat_idx_r + 1'b1;
	end

	// a byte is captured whole at its first bit, ready/busy included
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stat_sr_r <= '0;
			so_r      <= 1'b0;
		end
		else if (sck_fall && stat_act_r)
		begin
			if (stat_idx_r[2:0] == 3'h0)
			begin
				so_r      <= stat_byte[7];
				stat_sr_r <= {stat_byte[6:0], 1'b0};
			end
			else
			begin
				so_r      <= stat_sr_r[7];
				stat_sr_r <= {stat_sr_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			so_oe_r <= 1'b0;
		else if (cs_n_s)
			so_oe_r <= 1'b0;
		else if (sck_fall && stat_act_r)
			so_oe_r <= 1'b1;
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign so        = so_r;
	assign so_oe     = so_oe_r;
	assign busy      = busy_r;
	assign arr_start = start_r;
	assign arr_op    = op_r;
	assign arr_buf   = buf_r;
	assign arr_page  = page_r;
endmodule

//--- tb/fbc_host_model.sv
// host serial controller model driving the command link
`timescale 1ns/1ns
module fbc_host_model (
	input  wire logic        clk,
	input  wire logic        so,
	input  wire logic        so_oe,
	output logic             cs_n,
	output logic             sck,
	output logic             si,
	output logic             rd_stb,
	output logic      [31:0] rd_data
);
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rd_stb = 1'b0;
		rd_data = '0;
	end

	// one half period of the link clock, launched just after a clk edge
	task automatic half();
		repeat (4) @(posedge clk);
		#2;
	endtask

	// nb bits of w sent msb first, then nr bits read back
	task automatic frame(input logic [31:0] w, input int nb, input int nr, input logic stb);
		int i;
		rd_data = '0;
		half();
		cs_n = 1'b0;
		for (i = 0; i < nb + nr; i++)
		begin
			if (i < nb)
				si = w[31 - i];
			half();
			sck = 1'b1;
			repeat (4) @(posedge clk);
			if (i >= nb)
				rd_data = {rd_data[30:0], so_oe ? so : 1'bx};
			#2;
			sck = 1'b0;
		end
		half();
		cs_n = 1'b1;
		// released data line must not keep its last value
		si = ~si;
		rd_stb = stb;
		@(posedge clk);
		#2;
		rd_stb = 1'b0;
	endtask
endmodule

//--- tb/fbc_top_sva.sv
// checker: launch, busy and serial output relations at the block's ports
`timescale 1ns/1ns
module fbc_top_sva
	import fbc_pkg::*;
#(
	parameter int REWR_CYC = 625000
)(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              cs_n,
	input wire logic              sck,
	input wire logic              so,
	input wire logic              so_oe,
	input wire logic              busy,
	input wire logic              arr_start,
	input wire fbc_op_t           arr_op,
	input wire logic              arr_buf,
	input wire logic [PAGE_W-1:0] arr_page
);
	logic [CNT_W-1:0] busy_len_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busy_len_r <= '0;
		else
			busy_len_r <= busy ? busy_len_r + 1'b1 : '0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_start_pulse: assert property (arr_start |=> !arr_start)
		else $error("launch pulse longer than one cycle");
	a_start_busy: assert property (arr_start |=> busy)
		else $error("busy not raised after launch");
	a_start_idle: assert property (arr_start |-> !busy)
		else $error("launch while busy");
	a_start_cs: assert property (arr_start |-> $past(cs_n, 2))
		else $error("launch without chip select rise");
	a_busy_cause: assert property ($rose(busy) |-> $past(arr_start))
		else $error("busy without launch");
	a_busy_bound: assert property (busy_len_r <= REWR_CYC + 2)
		else $error("busy too long");
	a_oe_release: assert property (cs_n [*6] |-> !so_oe)
		else $error("output enabled while deselected");
	a_oe_select: assert property ($rose(so_oe) |-> !$past(cs_n, 3))
		else $error("output enabled without selection");
	a_so_edge: assert property (so_oe && $past(so_oe) && !$stable(so) |-> !$past(sck, 2))
		else $error("output changed away from falling clock");
	a_op_hold: assert property (!arr_start |-> $stable({arr_op, arr_buf, arr_page}))
		else $error("launch fields changed without launch");
endmodule

bind fbc_top fbc_top_sva #(.REWR_CYC(REWR_CYC)) fbc_top_sva_inst (.clk, .rst, .cs_n, .sck, .so,
	.so_oe, .busy, .arr_start, .arr_op, .arr_buf, .arr_page);

//--- tb/tb_fbc_top.sv
// testbench for the buffer command and status block
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_fbc_top;
	import fbc_pkg::*;
	// density value is arbitrary
	localparam logic [3:0] DENS = 4'ha;
	logic clk, rst, cs_n, sck, si, page_size_cfg, protect_en, arr_mismatch;
	logic so, so_oe, busy, arr_start, arr_buf, comp, rd_stb, b;
	fbc_op_t k;
	fbc_op_t arr_op;
	logic [PAGE_W-1:0] arr_page, page;
	logic [31:0] rd_data, exp_q[$];
	logic [10:0] dum;
	logic [23:0] addr;
	logic [7:0] opc[6] = '{OPC_XFER_B1, OPC_XFER_B2, OPC_CMP_B1, OPC_CMP_B2, OPC_REWR_B1,
		OPC_REWR_B2};
	int errors, check_count, cyc, seed, i;

	fbc_top #(.COPY_CYC(200), .CMP_CYC(200), .REWR_CYC(600), .DENSITY_CODE(DENS)) fbc_top_inst (
		.clk, .rst, .cs_n, .sck, .si, .page_size_cfg, .protect_en, .arr_mismatch, .so, .so_oe,
		.busy, .arr_start, .arr_op, .arr_buf, .arr_page);
	fbc_host_model fbc_host_model_inst (.clk, .so, .so_oe, .cs_n, .sck, .si, .rd_stb, .rd_data);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [7:0] st1(input logic rdy);
		return {rdy, comp, DENS, protect_en, page_size_cfg};
	endfunction

	task automatic chk(input logic [31:0] g);
		logic [31:0] e;
		e = exp_q.size() ? exp_q.pop_front() : 'x;
		`CHK(g, e)
	endtask

	task automatic end_of_test();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic status(input int nr, input logic [31:0] e);
		exp_q.push_back(e);
		fbc_host_model_inst.frame({OPC_STATUS, 24'h0}, 8, nr, 1'b1);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		repeat (8) @(posedge clk);
		while (busy !== 1'b0 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 3000)
			errors++;
		#2;
	endtask

	// results are compared in arrival order against the noted expectations
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (arr_start === 1'b1)
			chk({16'h0, arr_op, arr_buf, arr_page});
		if (rd_stb === 1'b1)
			chk(rd_data);
		if (cyc == 40000)
		begin
			errors++;
			end_of_test();
		end
	end

	initial
	begin
		seed = 32'h35302314;
		rst = 1'b1;
		page_size_cfg = 1'b0;
		protect_en = 1'b0;
		arr_mismatch = 1'b0;
		comp = 1'b0;
		cyc = 0;
		errors = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		#2;
		rst = 1'b0;
		status(32, {2{st1(1'b1), 8'h80}});
		for (i = 0; i < 12; i++)
		begin
			page_size_cfg = i[0];
			protect_en = $random(seed);
			arr_mismatch = $random(seed);
			page = $random(seed);
			dum = $random(seed);
			addr = i[0] ? {dum[1:0], page, dum[10:2]} : {dum[0], page, dum[10:1]};
			k = fbc_op_t'(i / 4);
			b = i[1];
			exp_q.push_back({16'h0, k, b, page});
			fbc_host_model_inst.frame({opc[i / 2], addr}, 32, 0, 1'b0);
			status(8, {24'h0, st1(1'b0)});
			if (k == FBC_OP_CMP)
				comp = arr_mismatch;
			// a command arriving mid-operation is dropped
			if (i == 9)
				fbc_host_model_inst.frame({OPC_XFER_B1, addr}, 32, 0, 1'b0);
			wait_idle();
			status(16, {16'h0, st1(1'b1), 8'h80});
		end
		fbc_host_model_inst.frame({OPC_XFER_B1, 24'h0}, 20, 0, 1'b0);
		fbc_host_model_inst.frame(32'ha5000000, 32, 0, 1'b0);
		fbc_host_model_inst.frame({OPC_STATUS, 24'h0}, 8, 3, 1'b0);
		repeat (6) @(posedge clk);
		`CHK(so_oe, 1'b0)
		repeat (20) @(posedge clk);
		end_of_test();
	end
endmodule
